// *** design/aic_chan_dec.sv ***
// Per-channel record source decoder with registered outputs, at most one source flag high
`timescale 1ns/1ps
module aic_chan_dec #(
   parameter bit PDM_ONLY = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst,
   aic_chan_if.dec   c
);
   // PDM-only channels read code 0 as "no source", never as analog
   always_ff @(posedge clk) begin
      if (rst) begin
         c.diff   <= 1'b0;
         c.se     <= 1'b0;
         c.pdm    <= 1'b0;
         c.dc_out <= aic_pkg::DC_RST;
         c.mix_ok <= 1'b0;
      end else begin
         c.diff   <= !PDM_ONLY && (c.src == aic_pkg::SRC_DIFF);
         c.se     <= !PDM_ONLY && (c.src == aic_pkg::SRC_SE);
         c.pdm    <= (c.src == aic_pkg::SRC_PDM);
         c.dc_out <= c.dc;
         // Summing path exists only behind the first two channels
         c.mix_ok <= !PDM_ONLY && (c.src != aic_pkg::CODE_RSVD);
      end
   end
endmodule

// *** design/aic_if.sv ***
// Interfaces between the config top, the channel decoders and the charge timers
`timescale 1ns/1ps
interface aic_chan_if;
   logic [1:0] src;
   logic       dc;
   logic       diff;
   logic       se;
   logic       pdm;
   logic       dc_out;
   logic       mix_ok;
   modport cfg (output src, output dc, input diff, input se, input pdm, input dc_out, input mix_ok);
   modport dec (input src, input dc, output diff, output se, output pdm, output dc_out, output mix_ok);
endinterface

interface aic_tmr_if;
   logic        start;
   logic        stop;
   logic [31:0] load;
   logic        busy;
   modport ctl (output start, output stop, output load, input busy);
   modport tmr (input start, input stop, input load, output busy);
endinterface

// *** design/aic_pkg.sv ***
// Package: register map, field layout, reset values and timing of the input config block
package aic_pkg;
   // -----------------------------------------------------------------
   // Register indexes (byte address = index * 4)
   // -----------------------------------------------------------------
   localparam int unsigned AW        = 12;
   localparam logic [9:0]  IDX_PWR   = 10'h002;
   localparam logic [9:0]  IDX_GEN   = 10'h005;
   localparam logic [9:0]  IDX_CMTOL = 10'h03A;
   localparam logic [9:0]  IDX_REF   = 10'h03B;
   localparam logic [9:0]  IDX_CH [4] = '{10'h03C, 10'h041, 10'h046, 10'h04B};
   localparam logic [9:0]  IDX_STAT  = 10'h07F;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int unsigned SRC_LO    = 5;
   localparam int unsigned DC_BIT    = 4;
   localparam int unsigned IMP_LO    = 2;
   localparam int unsigned CM1_LO    = 6;
   localparam int unsigned CM2_LO    = 4;
   localparam int unsigned FS_LO     = 0;
   localparam int unsigned CAPQ_LO   = 4;
   localparam int unsigned REFQ_LO   = 3;
   localparam int unsigned SLEEP_BIT = 0;

   // -----------------------------------------------------------------
   // Encodings and reset values
   // -----------------------------------------------------------------
   localparam logic [1:0] SRC_DIFF  = 2'h0;
   localparam logic [1:0] SRC_SE    = 2'h1;
   localparam logic [1:0] SRC_PDM   = 2'h2;
   localparam logic [1:0] CODE_RSVD = 2'h3;
   localparam logic [1:0] FLD_RST   = 2'h0;
   localparam logic       DC_RST    = 1'b0;
   localparam logic       SLEEP_RST = 1'b1;
   localparam logic [2:0] OH_RST    = 3'h1;

   // -----------------------------------------------------------------
   // Timing: times in microseconds, counts at the clock rate
   // -----------------------------------------------------------------
   localparam int unsigned CLK_MHZ      = 250;
   localparam int unsigned REF_CHG_US_0 = 3500;
   localparam int unsigned REF_CHG_US_1 = 10000;
   localparam int unsigned REF_CHG_US_2 = 50000;
   localparam int unsigned REF_CHG_US_3 = 100000;
   localparam int unsigned CAP_PRE_US_0 = 1000;
   localparam int unsigned CAP_PRE_US_1 = 2000;
   localparam int unsigned CAP_PRE_US_2 = 5000;
   localparam int unsigned CAP_PRE_US_3 = 10000;
   localparam int unsigned REF_CHG_CYC_0 = REF_CHG_US_0 * CLK_MHZ;
   localparam int unsigned REF_CHG_CYC_1 = REF_CHG_US_1 * CLK_MHZ;
   localparam int unsigned REF_CHG_CYC_2 = REF_CHG_US_2 * CLK_MHZ;
   localparam int unsigned REF_CHG_CYC_3 = REF_CHG_US_3 * CLK_MHZ;
   localparam int unsigned CAP_PRE_CYC_0 = CAP_PRE_US_0 * CLK_MHZ;
   localparam int unsigned CAP_PRE_CYC_1 = CAP_PRE_US_1 * CLK_MHZ;
   localparam int unsigned CAP_PRE_CYC_2 = CAP_PRE_US_2 * CLK_MHZ;
   localparam int unsigned CAP_PRE_CYC_3 = CAP_PRE_US_3 * CLK_MHZ;
endpackage

// *** design/aic_timer.sv ***
// Countdown timer that holds busy for exactly the loaded number of cycles
`timescale 1ns/1ps
module aic_timer (
   input  wire logic clk,
   input  wire logic rst,
   aic_tmr_if.tmr    t
);
   logic [31:0] cnt_q;

   // Load wins over stop; stop aborts a charge when sleep returns
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 32'h0;
      end else if (t.start) begin
         cnt_q <= t.load;
      end else if (t.stop) begin
         cnt_q <= 32'h0;
      end else if (cnt_q != 32'h0) begin
         cnt_q <= cnt_q - 32'h1;
      end
   end

   assign t.busy = (cnt_q != 32'h0);
endmodule

// *** design/aic_top.sv ***
// APB register bank and decode for record inputs, reference and charge timing
`timescale 1ns/1ps
// Behaviour
// - ch1 source: diff, single-ended, PDM; 11 ignored
// - ch2-4 own source field at bits 6:5
// - per-channel DC coupling bit 4
// - four PDM or two analog plus two PDM
// - ch1 impedance 2.5k, 10k, 20k; 11 ignored
// - ch2 impedance field bits 3:2, same coding
// - precharge field lengthens coupling-cap charge time
// - ch1 common-mode mode at bits 7:6
// - ch2 common-mode mode at bits 5:4
// - full-scale reference 2.75, 2.5, 1.375 V
// - reference off in sleep, fast-charge on wake
// - fast-charge field at bits 4:3, four durations
// - channels 3 and 4 PDM only, no mixing
module aic_top #(
   parameter int unsigned REF_CHG_CYC_0 = aic_pkg::REF_CHG_CYC_0,
   parameter int unsigned REF_CHG_CYC_1 = aic_pkg::REF_CHG_CYC_1,
   parameter int unsigned REF_CHG_CYC_2 = aic_pkg::REF_CHG_CYC_2,
   parameter int unsigned REF_CHG_CYC_3 = aic_pkg::REF_CHG_CYC_3,
   parameter int unsigned CAP_PRE_CYC_0 = aic_pkg::CAP_PRE_CYC_0,
   parameter int unsigned CAP_PRE_CYC_1 = aic_pkg::CAP_PRE_CYC_1,
   parameter int unsigned CAP_PRE_CYC_2 = aic_pkg::CAP_PRE_CYC_2,
   parameter int unsigned CAP_PRE_CYC_3 = aic_pkg::CAP_PRE_CYC_3
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [aic_pkg::AW-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   output logic      [3:0]             ch_src_diff,
   output logic      [3:0]             ch_src_se,
   output logic      [3:0]             ch_src_pdm,
   output logic      [3:0]             ch_dc_coupled,
   output logic      [3:0]             ch_mix_allowed,
   output logic      [2:0]             ch1_input_impedance_sel_oh,
   output logic      [2:0]             ch2_input_impedance_sel_oh,
   output logic      [2:0]             ch1_cm_oh,
   output logic      [2:0]             ch2_cm_oh,
   output logic      [2:0]             fullscale_oh,
   output logic                        pdm_pins_active,
   output logic                        ref_power_on,
   output logic                        ref_fast_charge_active,
   output logic                        ref_ready,
   output logic                        cap_precharge_active
);
   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic [9:0]  idx;
   logic        wr;
   logic        setup;
   logic [1:0]  rec_src_q [4];
   logic [3:0]  dc_q;
   logic [1:0]  ch1_input_impedance_sel_q;
   logic [1:0]  ch2_input_impedance_sel_q;
   logic [1:0]  ch1_common_mode_tolerance_q;
   logic [1:0]  ch2_common_mode_tolerance_q;
   logic [1:0]  fullscale_reference_sel_q;
   logic [1:0]  reference_fast_charge_time_q;
   logic [1:0]  coupling_cap_precharge_time_q;
   logic        sleep_q;
   logic        ref_ready_q;
   logic [31:0] rd_d;
   logic        err_d;
   logic [31:0] prdata_q;
   logic        pslverr_q;
   logic        wake;
   logic        go_sleep;
   logic [1:0]  refq_new;

   aic_tmr_if ref_t ();
   aic_tmr_if cap_t ();

   assign idx    = paddr[aic_pkg::AW-1:2];
   assign setup  = psel && !penable;
   assign wr     = psel && penable && pwrite;
   // Zero-wait slave; read data was captured in the setup cycle
   assign pready  = psel && penable;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q && psel && penable;

   // Reserved code 11 leaves the field as it was
   function automatic logic [1:0] keep(input logic [1:0] old, input logic [1:0] nw);
      keep = (nw == aic_pkg::CODE_RSVD) ? old : nw;
   endfunction

   // ----------------------------------------------------------------
   // Channel registers and decoders
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_ch
         aic_chan_if ci ();
         // Source and coupling per channel
         always_ff @(posedge clk) begin
            if (rst) begin
               rec_src_q[g] <= aic_pkg::FLD_RST;
               dc_q[g]      <= aic_pkg::DC_RST;
            end else if (wr && idx == aic_pkg::IDX_CH[g]) begin
               dc_q[g] <= pwdata[aic_pkg::DC_BIT];
               if (g >= 2) begin
                  // Only PDM or "off" is taken on the upper pair
                  if (pwdata[aic_pkg::SRC_LO +: 2] == aic_pkg::SRC_PDM ||
                      pwdata[aic_pkg::SRC_LO +: 2] == aic_pkg::FLD_RST) begin
                     rec_src_q[g] <= pwdata[aic_pkg::SRC_LO +: 2];
                  end
               end else begin
                  rec_src_q[g] <= keep(rec_src_q[g], pwdata[aic_pkg::SRC_LO +: 2]);
               end
            end
         end
         assign ci.src = rec_src_q[g];
         assign ci.dc  = dc_q[g];
         aic_chan_dec #(.PDM_ONLY(g >= 2)) u_dec (
            .clk (clk),
            .rst (rst),
            .c   (ci)
         );
         assign ch_src_diff[g]    = ci.diff;
         assign ch_src_se[g]      = ci.se;
         assign ch_src_pdm[g]     = ci.pdm;
         assign ch_dc_coupled[g]  = ci.dc_out;
         assign ch_mix_allowed[g] = ci.mix_ok;
      end
   endgenerate

   // Impedance fields of the two analog channels
   always_ff @(posedge clk) begin
      if (rst) begin
         ch1_input_impedance_sel_q <= aic_pkg::FLD_RST;
         ch2_input_impedance_sel_q <= aic_pkg::FLD_RST;
      end else if (wr && idx == aic_pkg::IDX_CH[0]) begin
         ch1_input_impedance_sel_q <= keep(ch1_input_impedance_sel_q, pwdata[aic_pkg::IMP_LO +: 2]);
      end else if (wr && idx == aic_pkg::IDX_CH[1]) begin
         ch2_input_impedance_sel_q <= keep(ch2_input_impedance_sel_q, pwdata[aic_pkg::IMP_LO +: 2]);
      end
   end

   // Common-mode tolerance, both channels in one register
   always_ff @(posedge clk) begin
      if (rst) begin
         ch1_common_mode_tolerance_q <= aic_pkg::FLD_RST;
         ch2_common_mode_tolerance_q <= aic_pkg::FLD_RST;
      end else if (wr && idx == aic_pkg::IDX_CMTOL) begin
         ch1_common_mode_tolerance_q <= keep(ch1_common_mode_tolerance_q, pwdata[aic_pkg::CM1_LO +: 2]);
         ch2_common_mode_tolerance_q <= keep(ch2_common_mode_tolerance_q, pwdata[aic_pkg::CM2_LO +: 2]);
      end
   end

   // Reference level and precharge length
   always_ff @(posedge clk) begin
      if (rst) begin
         fullscale_reference_sel_q     <= aic_pkg::FLD_RST;
         coupling_cap_precharge_time_q <= aic_pkg::FLD_RST;
      end else if (wr && idx == aic_pkg::IDX_REF) begin
         fullscale_reference_sel_q <= keep(fullscale_reference_sel_q, pwdata[aic_pkg::FS_LO +: 2]);
      end else if (wr && idx == aic_pkg::IDX_GEN) begin
         coupling_cap_precharge_time_q <= pwdata[aic_pkg::CAPQ_LO +: 2];
      end
   end

   // Registered one-hot decode, same latency as the channel decoders
   always_ff @(posedge clk) begin
      if (rst) begin
         ch1_input_impedance_sel_oh   <= aic_pkg::OH_RST;
         ch2_input_impedance_sel_oh   <= aic_pkg::OH_RST;
         ch1_cm_oh    <= aic_pkg::OH_RST;
         ch2_cm_oh    <= aic_pkg::OH_RST;
         fullscale_oh <= aic_pkg::OH_RST;
      end else begin
         ch1_input_impedance_sel_oh   <= 3'(aic_pkg::OH_RST << ch1_input_impedance_sel_q);
         ch2_input_impedance_sel_oh   <= 3'(aic_pkg::OH_RST << ch2_input_impedance_sel_q);
         ch1_cm_oh    <= 3'(aic_pkg::OH_RST << ch1_common_mode_tolerance_q);
         ch2_cm_oh    <= 3'(aic_pkg::OH_RST << ch2_common_mode_tolerance_q);
         fullscale_oh <= 3'(aic_pkg::OH_RST << fullscale_reference_sel_q);
      end
   end

   // ----------------------------------------------------------------
   // Sleep, reference fast charge and coupling-cap precharge
   // ----------------------------------------------------------------
   // Wake uses the charge code written in the same access
   assign refq_new = pwdata[aic_pkg::REFQ_LO +: 2];
   assign wake     = wr && idx == aic_pkg::IDX_PWR && sleep_q && !pwdata[aic_pkg::SLEEP_BIT];
   assign go_sleep = wr && idx == aic_pkg::IDX_PWR && !sleep_q && pwdata[aic_pkg::SLEEP_BIT];

   always_ff @(posedge clk) begin
      if (rst) begin
         sleep_q                      <= aic_pkg::SLEEP_RST;
         reference_fast_charge_time_q <= aic_pkg::FLD_RST;
      end else if (wr && idx == aic_pkg::IDX_PWR) begin
         sleep_q                      <= pwdata[aic_pkg::SLEEP_BIT];
         reference_fast_charge_time_q <= refq_new;
      end
   end

   // Duration per code; counts are parameters so a bench can shrink them
   always_comb begin
      case (refq_new)
         2'h0:    ref_t.load = 32'(REF_CHG_CYC_0);
         2'h1:    ref_t.load = 32'(REF_CHG_CYC_1);
         2'h2:    ref_t.load = 32'(REF_CHG_CYC_2);
         default: ref_t.load = 32'(REF_CHG_CYC_3);
      endcase
      case (coupling_cap_precharge_time_q)
         2'h0:    cap_t.load = 32'(CAP_PRE_CYC_0);
         2'h1:    cap_t.load = 32'(CAP_PRE_CYC_1);
         2'h2:    cap_t.load = 32'(CAP_PRE_CYC_2);
         default: cap_t.load = 32'(CAP_PRE_CYC_3);
      endcase
   end
   assign ref_t.start = wake;
   assign ref_t.stop  = go_sleep;
   assign cap_t.start = wake;
   assign cap_t.stop  = go_sleep;

   aic_timer u_ref_tmr (
      .clk (clk),
      .rst (rst),
      .t   (ref_t)
   );
   aic_timer u_cap_tmr (
      .clk (clk),
      .rst (rst),
      .t   (cap_t)
   );

   // Ready one cycle after the charge ends, cleared by sleep
   always_ff @(posedge clk) begin
      if (rst) begin
         ref_ready_q <= 1'b0;
      end else begin
         ref_ready_q <= !sleep_q && !ref_t.busy && !go_sleep;
      end
   end

   assign ref_power_on           = !sleep_q;
   assign ref_fast_charge_active = ref_t.busy;
   assign cap_precharge_active   = cap_t.busy;
   assign ref_ready              = ref_ready_q;
   assign pdm_pins_active        = |ch_src_pdm;

   // ----------------------------------------------------------------
   // Read path, captured in the setup cycle
   // ----------------------------------------------------------------
   always_comb begin
      rd_d  = 32'h0;
      err_d = 1'b0;
      if (idx == aic_pkg::IDX_PWR) begin
         rd_d[aic_pkg::SLEEP_BIT]    = sleep_q;
         rd_d[aic_pkg::REFQ_LO +: 2] = reference_fast_charge_time_q;
      end else if (idx == aic_pkg::IDX_GEN) begin
         rd_d[aic_pkg::CAPQ_LO +: 2] = coupling_cap_precharge_time_q;
      end else if (idx == aic_pkg::IDX_CMTOL) begin
         rd_d[aic_pkg::CM1_LO +: 2] = ch1_common_mode_tolerance_q;
         rd_d[aic_pkg::CM2_LO +: 2] = ch2_common_mode_tolerance_q;
      end else if (idx == aic_pkg::IDX_REF) begin
         rd_d[aic_pkg::FS_LO +: 2] = fullscale_reference_sel_q;
      end else if (idx == aic_pkg::IDX_CH[0]) begin
         rd_d[aic_pkg::SRC_LO +: 2] = rec_src_q[0];
         rd_d[aic_pkg::DC_BIT]      = dc_q[0];
         rd_d[aic_pkg::IMP_LO +: 2] = ch1_input_impedance_sel_q;
      end else if (idx == aic_pkg::IDX_CH[1]) begin
         rd_d[aic_pkg::SRC_LO +: 2] = rec_src_q[1];
         rd_d[aic_pkg::DC_BIT]      = dc_q[1];
         rd_d[aic_pkg::IMP_LO +: 2] = ch2_input_impedance_sel_q;
      end else if (idx == aic_pkg::IDX_CH[2]) begin
         rd_d[aic_pkg::SRC_LO +: 2] = rec_src_q[2];
         rd_d[aic_pkg::DC_BIT]      = dc_q[2];
      end else if (idx == aic_pkg::IDX_CH[3]) begin
         rd_d[aic_pkg::SRC_LO +: 2] = rec_src_q[3];
         rd_d[aic_pkg::DC_BIT]      = dc_q[3];
      end else if (idx == aic_pkg::IDX_STAT) begin
         rd_d[4:0] = {pdm_pins_active, cap_t.busy, ref_ready_q, ref_t.busy, !sleep_q};
      end else begin
         err_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prdata_q  <= 32'h0;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q  <= pwrite ? 32'h0 : rd_d;
         pslverr_q <= err_d;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   logic [31:0] chg_cnt_q;
   logic [31:0] chg_exp_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         chg_cnt_q <= 32'h0;
         chg_exp_q <= 32'h0;
      end else if (ref_t.start) begin
         chg_cnt_q <= 32'h0;
         chg_exp_q <= ref_t.load;
      end else if (ref_t.busy) begin
         chg_cnt_q <= chg_cnt_q + 32'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_SRC_RSVD_KEPT: assert property (wr && idx == aic_pkg::IDX_CH[0] && pwdata[6:5] == 2'h3 |=>
      $stable(rec_src_q[0])) else $error("reserved source code changed channel 1");
   AST_SRC_CH2_SE: assert property (wr && idx == aic_pkg::IDX_CH[1] && pwdata[6:5] == 2'h1 |->
      ##2 ch_src_se[1] && !ch_src_diff[1]) else $error("channel 2 single-ended not decoded");
   AST_DC_CH4: assert property (wr && idx == aic_pkg::IDX_CH[3] |->
      ##2 ch_dc_coupled[3] == $past(pwdata[4], 2)) else $error("channel 4 coupling bit lost");
   AST_IMP_CH1: assert property (wr && idx == aic_pkg::IDX_CH[0] && pwdata[3:2] == 2'h2 |->
      ##2 ch1_input_impedance_sel_oh == 3'h4) else $error("channel 1 impedance 20k not decoded");
   AST_IMP_CH2: assert property (wr && idx == aic_pkg::IDX_CH[1] && pwdata[3:2] == 2'h1 |->
      ##2 ch2_input_impedance_sel_oh == 3'h2) else $error("channel 2 impedance 10k not decoded");
   AST_CM_CH1: assert property (wr && idx == aic_pkg::IDX_CMTOL && pwdata[7:6] == 2'h2 |->
      ##2 ch1_cm_oh == 3'h4) else $error("channel 1 high-CMRR not decoded");
   AST_CM_CH2: assert property (wr && idx == aic_pkg::IDX_CMTOL && pwdata[5:4] == 2'h1 |->
      ##2 ch2_cm_oh == 3'h2) else $error("channel 2 intermediate mode not decoded");
   AST_FS_RSVD: assert property (wr && idx == aic_pkg::IDX_REF && pwdata[1:0] == 2'h3 |=>
      ##1 $stable(fullscale_oh)) else $error("reserved full-scale code took effect");
   AST_SLEEP_OFF: assert property (sleep_q |-> !ref_power_on && !ref_ready && !ref_fast_charge_active)
      else $error("reference active during sleep");
   AST_CHG_LEN: assert property ($fell(ref_t.busy) && !sleep_q |-> chg_cnt_q == chg_exp_q)
      else $error("fast-charge length differs from selected code");
   AST_WAKE_LOAD: assert property (wake && refq_new == 2'h1 |=> ref_fast_charge_active &&
      chg_exp_q == 32'(REF_CHG_CYC_1)) else $error("fast-charge code 1 not loaded on wake");
   AST_PDM_ONLY: assert property (ch_src_diff[3:2] == 2'h0 && ch_src_se[3:2] == 2'h0 &&
      ch_mix_allowed[3:2] == 2'h0) else $error("upper channels left PDM-only mode");
   AST_PRECHG_WAKE: assert property ($rose(cap_precharge_active) |-> $past(sleep_q))
      else $error("precharge started without a wake");

   COV_WAKE_READY: cover property (wake ##1 ref_fast_charge_active [*3] ##[1:1000] $rose(ref_ready));
   COV_MIXED: cover property (ch_src_diff[0] && ch_src_se[1] && ch_src_pdm[2] && ch_src_pdm[3]);
   COV_ALL_PDM: cover property (ch_src_pdm == 4'hF);
   COV_RSVD_WR: cover property (wr && idx == aic_pkg::IDX_CH[0] && pwdata[6:5] == 2'h3);
endmodule

// *** tb/adc_input_channel_config_test.sv ***
// Self-checking bench for the record input and reference configuration block
`timescale 1ns/1ps
module adc_input_channel_config_test;
   logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, chk_q = 0, d;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic        pready, pslverr, pdm_pins_active, ref_power_on, ref_fast_charge_active, ref_ready, cap_pre;
   logic [3:0]  ch_src_diff, ch_src_se, ch_src_pdm, ch_dc_coupled, ch_mix_allowed, ed, es, ep, dc = '0;
   logic [2:0]  ch1_input_impedance_sel_oh, ch2_input_impedance_sel_oh, ch1_cm_oh, ch2_cm_oh, fullscale_oh;
   logic [1:0]  c, m, fs = '0, src[4] = '{default: 2'h0}, imp[2] = '{default: 2'h0}, cm[2] = '{default: 2'h0};
   logic [32:0] rdq[$], rx;
   logic [35:0] outq[$], ex;
   int          chq[$], run = 0, fail_count = 0, n_compared = 0, i, it;
   wire  [4:0]  pins = {pdm_pins_active, cap_pre, ref_ready, ref_fast_charge_active, ref_power_on};
   wire  [35:0] outs = {ch_src_diff, ch_src_se, ch_src_pdm, ch_dc_coupled, ch_mix_allowed, pdm_pins_active,
                        ch1_input_impedance_sel_oh, ch2_input_impedance_sel_oh, ch1_cm_oh, ch2_cm_oh, fullscale_oh};
   localparam int REF_C[4] = '{8, 12, 16, 20};

   // Short reference counts; longer precharge codes keep full length, so they outlast any wait here
   aic_top #(.REF_CHG_CYC_0(8), .REF_CHG_CYC_1(12), .REF_CHG_CYC_2(16), .REF_CHG_CYC_3(20),
             .CAP_PRE_CYC_0(8)) u_dut (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_src_diff(ch_src_diff),
      .ch_src_se(ch_src_se), .ch_src_pdm(ch_src_pdm), .ch_dc_coupled(ch_dc_coupled),
      .ch_mix_allowed(ch_mix_allowed), .ch1_input_impedance_sel_oh(ch1_input_impedance_sel_oh), .ch2_input_impedance_sel_oh(ch2_input_impedance_sel_oh),
      .ch1_cm_oh(ch1_cm_oh), .ch2_cm_oh(ch2_cm_oh), .fullscale_oh(fullscale_oh),
      .pdm_pins_active(pdm_pins_active), .ref_power_on(ref_power_on),
      .ref_fast_charge_active(ref_fast_charge_active), .ref_ready(ref_ready), .cap_precharge_active(cap_pre));

   always #2 clk = ~clk;

   function automatic logic [2:0] oh(input logic [1:0] v);
      return 3'h1 << v;
   endfunction

   task automatic check(input logic [63:0] e, input logic [63:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   // One compare per kind of result, all counted and reported by check
   task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
      check(64'(e), 64'(g));
   endtask

   task automatic cmp_out(input logic [35:0] e, input logic [35:0] g);
      check(64'(e), 64'(g));
   endtask

   task automatic cmp_pin(input logic [4:0] e, input logic [4:0] g);
      check(64'(e), 64'(g));
   endtask

   task automatic cmp_len(input logic [31:0] e, input logic [31:0] g);
      check(64'(e), 64'(g));
   endtask

   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // APB cycle; the master holds everything until pready is seen high, only the watchdog ends a hang
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'h0};
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [9:0] idx, input logic [32:0] e);
      rdq.push_back(e);
      apb(0, idx, 32'h0);
   endtask

   // Decoded outputs settle one edge after the write edge, so wait three
   task automatic snap(input logic [35:0] e);
      outq.push_back(e);
      repeat (3) @(posedge clk);
      chk_q <= 1;
      @(posedge clk);
      chk_q <= 0;
   endtask

   // Watcher: read data, output snapshots and fast-charge run length
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite) begin
         rx = rdq.pop_front();
         cmp_rd(rx, {pslverr, prdata});
         // Status pins must agree with the status word just read
         if (paddr[11:2] == aic_pkg::IDX_STAT) begin
            cmp_pin(rx[4:0], pins);
         end
      end
      if (chk_q) cmp_out(outq.pop_front(), outs);
      if (ref_fast_charge_active === 1'b1) run++;
      else if (run != 0) begin
         cmp_len(32'(chq.pop_front()), 32'(run));
         run = 0;
      end
   end

   // Watchdog reckoned well above the expected run
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      test_done;
   end

   initial begin
      void'($urandom(34));
      repeat (10) @(posedge clk);
      rst <= 0;
      rd(aic_pkg::IDX_PWR, 33'h1);
      rd(10'h100, {1'b1, 32'h0});
      $display("test reset_and_unmapped done");
      // Wake with every fast-charge code, then back to sleep
      for (i = 0; i < 4; i++) begin
         chq.push_back(REF_C[i]);
         apb(1, aic_pkg::IDX_PWR, 32'(i) << 3);
         repeat (40) @(posedge clk);
         rd(aic_pkg::IDX_STAT, 33'h5);
         apb(1, aic_pkg::IDX_PWR, 32'h1);
         rd(aic_pkg::IDX_STAT, 33'h0);
      end
      // Precharge code 1 must still run once the reference is ready
      apb(1, aic_pkg::IDX_GEN, 32'h10);
      rd(aic_pkg::IDX_GEN, 33'h10);
      chq.push_back(REF_C[0]);
      apb(1, aic_pkg::IDX_PWR, 32'h0);
      repeat (40) @(posedge clk);
      rd(aic_pkg::IDX_STAT, 33'hD);
      apb(1, aic_pkg::IDX_PWR, 32'h1);
      rd(aic_pkg::IDX_STAT, 33'h0);
      $display("test wake_charge done");
      // Random codes, reserved ones included, on the channel, common-mode and full-scale fields
      for (it = 0; it < 24; it++) begin
         for (i = 0; i < 4; i++) begin
            c = 2'($urandom); d = 1'($urandom); m = 2'($urandom);
            // High-CMRR mode never left beside the 2.5k impedance
            if (i < 2 && cm[i] == 2'h2 && m == 2'h0) m = 2'h1;
            // No pin functions here, so any analog or PDM choice keeps the pin rules
            apb(1, aic_pkg::IDX_CH[i], {25'h0, c, d, m, 2'h0});
            if (c != 2'h3 && !(i > 1 && c == 2'h1)) src[i] = c;
            dc[i] = d;
            if (i < 2 && m != 2'h3) imp[i] = m;
            ed[i] = (i < 2) && src[i] == 2'h0; es[i] = src[i] == 2'h1; ep[i] = src[i] == 2'h2;
         end
         c = 2'($urandom); m = 2'($urandom);
         if (imp[0] == 2'h0 && (c == 2'h2 || (c == 2'h3 && cm[0] == 2'h2))) c = 2'h1;
         if (imp[1] == 2'h0 && (m == 2'h2 || (m == 2'h3 && cm[1] == 2'h2))) m = 2'h1;
         apb(1, aic_pkg::IDX_CMTOL, {24'h0, c, m, 4'h0});
         if (c != 2'h3) cm[0] = c;
         if (m != 2'h3) cm[1] = m;
         c = 2'($urandom);
         apb(1, aic_pkg::IDX_REF, {30'h0, c});
         if (c != 2'h3) fs = c;
         rd(aic_pkg::IDX_CH[0], {26'h0, src[0], dc[0], imp[0], 2'h0});
         // Summing allowed on the two analog-capable channels only
         ex = {ed, es, ep, dc, 4'h3, |ep, oh(imp[0]), oh(imp[1]), oh(cm[0]), oh(cm[1]), oh(fs)};
         snap(ex);
      end
      $display("test random_fields done");
      test_done;
   end
endmodule
